// >>> piit_pkg.sv
package piit_pkg;
  // ---------------------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------------------
  localparam int INTERVAL_W = 32;
  localparam int SCALAR_W = 64;
  localparam logic [31:0] INTERVAL_RST = 32'h0000_0000;
  localparam logic [31:0] COUNT_ZERO = 32'h0000_0000;
  localparam logic [31:0] COUNT_STEP = 32'h0000_0001;

  // ---------------------------------------------------------------------------
  // Operation codes presented by the issue logic
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    PIIT_OP_NONE = 3'b000,
    PIIT_OP_LOAD = 3'b001,
    PIIT_OP_CLEAR = 3'b010,
    PIIT_OP_ENABLE = 3'b011,
    PIIT_OP_DISABLE = 3'b100
  } piit_op_t;

  // Command carried from issue logic
  typedef struct packed {
    logic valid;
    piit_op_t op;
    logic [63:0] scalar_source_reg;
  } piit_cmd_t;

  // Status reported back to the processor
  typedef struct packed {
    logic request_pending;
    logic request_enabled;
    logic interrupt_req;
  } piit_stat_t;
endpackage

// >>> piit_counter.sv
`timescale 1ns/1ps
module piit_counter #(
  parameter int W = 32
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] load_value,
  input wire logic [W-1:0] reload_value,
  output logic [W-1:0] countdown_counter,
  output logic expire
);
  // ---------------------------------------------------------------------------
  // Countdown counter
  // ---------------------------------------------------------------------------
  // Zero detect is high in every cycle the count sits at zero, unless a load arrives in that cycle
  assign expire = (countdown_counter == W'(piit_pkg::COUNT_ZERO)) && !load;

  // Preset on load, reload on zero, else decrement by one each period
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      countdown_counter <= W'(piit_pkg::INTERVAL_RST);
    end else if (load) begin
      countdown_counter <= load_value;
    end else if (countdown_counter == W'(piit_pkg::COUNT_ZERO)) begin
      countdown_counter <= reload_value;
    end else begin
      countdown_counter <= countdown_counter - W'(piit_pkg::COUNT_STEP);
    end
  end
endmodule

// >>> piit_timer.sv
`timescale 1ns/1ps
module piit_timer #(
  parameter int W = piit_pkg::INTERVAL_W
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire piit_pkg::piit_cmd_t cmd,
  input wire logic monitor_mode,
  output logic [W-1:0] timer_interval,
  output logic [W-1:0] countdown_counter,
  output piit_pkg::piit_stat_t status,
  output logic interrupt_req
);
  // ---------------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------------
  logic rst_meta;
  logic rst_sync_n;
  // Two-stage release of master clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // ---------------------------------------------------------------------------
  // Operation decode
  // ---------------------------------------------------------------------------
  logic do_load;
  logic do_clear;
  logic do_enable;
  logic do_disable;
  logic expire;
  logic request_enabled;
  logic request_pending;
  logic [W-1:0] load_value;

  // Privileged ops come only in monitor mode, so no mode check here
  assign do_load = cmd.valid && (cmd.op == piit_pkg::PIIT_OP_LOAD);
  assign do_clear = cmd.valid && (cmd.op == piit_pkg::PIIT_OP_CLEAR);
  assign do_enable = cmd.valid && (cmd.op == piit_pkg::PIIT_OP_ENABLE);
  assign do_disable = cmd.valid && (cmd.op == piit_pkg::PIIT_OP_DISABLE);
  assign load_value = cmd.scalar_source_reg[W-1:0];

  // ---------------------------------------------------------------------------
  // Interval register
  // ---------------------------------------------------------------------------
  // Written only by the load operation
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      timer_interval <= W'(piit_pkg::INTERVAL_RST);
    end else if (do_load) begin
      timer_interval <= load_value;
    end
  end

  // ---------------------------------------------------------------------------
  // Countdown
  // ---------------------------------------------------------------------------
  piit_counter #(
    .W(W)
  ) u_counter (
    .mclk(mclk),
    .rst_n(rst_sync_n),
    .load(do_load),
    .load_value(load_value),
    .reload_value(timer_interval),
    .countdown_counter(countdown_counter),
    .expire(expire)
  );

  // ---------------------------------------------------------------------------
  // Enable latch
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      request_enabled <= 1'b0;
    end else if (do_enable) begin
      request_enabled <= 1'b1;
    end else if (do_disable) begin
      request_enabled <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Request latch
  // ---------------------------------------------------------------------------
  // Expiry wins over a clear in the same cycle so no event is lost
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      request_pending <= 1'b0;
    end else if (expire && request_enabled) begin
      request_pending <= 1'b1;
    end else if (do_clear) begin
      request_pending <= 1'b0;
    end
  end

  // Request is held in monitor mode and acts in user mode
  assign interrupt_req = request_pending && !monitor_mode;

  assign status.request_pending = request_pending;
  assign status.request_enabled = request_enabled;
  assign status.interrupt_req = interrupt_req;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_sync_n);

  load_interval_a: assert property (do_load |=> timer_interval == $past(load_value))
    else $error("interval not loaded");
  interval_hold_a: assert property (!do_load |=> $stable(timer_interval))
    else $error("interval changed without load");
  load_preset_a: assert property (do_load |=> countdown_counter == $past(load_value))
    else $error("counter not preset");
  count_step_a: assert property (!do_load && countdown_counter != '0
    |=> countdown_counter == $past(countdown_counter) - W'(1))
    else $error("counter did not step down");
  zero_reload_a: assert property (!do_load && countdown_counter == '0
    |=> countdown_counter == $past(timer_interval))
    else $error("counter did not reload");
  request_set_a: assert property (expire && request_enabled |=> request_pending)
    else $error("request not raised");
  request_hold_a: assert property (request_pending && !do_clear |=> request_pending)
    else $error("request dropped early");
  clear_drop_a: assert property (do_clear && !(expire && request_enabled)
    |=> !request_pending)
    else $error("clear ignored");
  gate_enable_a: assert property (!request_pending && !request_enabled |=> !request_pending)
    else $error("request set while disabled");
  enable_latch_a: assert property (do_enable |=> request_enabled)
    else $error("enable ignored");
  disable_latch_a: assert property (do_disable && !do_enable |=> !request_enabled)
    else $error("disable ignored");
  monitor_mask_a: assert property (monitor_mode |-> !interrupt_req)
    else $error("interrupt in monitor mode");
  user_release_a: assert property (request_pending && !monitor_mode |-> interrupt_req)
    else $error("pending request not delivered");

  periodic_c: cover property (expire ##1 !expire [*5] ##1 expire);
  held_c: cover property (request_pending && monitor_mode ##1 !monitor_mode);
  clear_c: cover property (request_pending ##1 do_clear ##1 !request_pending);
  collide_c: cover property (expire && request_enabled && do_clear);
endmodule

// >>> piit_issue_model.sv
`timescale 1ns/1ps
module piit_issue_model (
  input wire logic mclk,
  output piit_pkg::piit_cmd_t cmd,
  output logic monitor_mode
);
  initial begin
    cmd = '0;
    monitor_mode = 1'b1;
  end
  // Presents one op for one edge, only ever in monitor mode; back to back calls keep valid up
  task automatic issue(input piit_pkg::piit_op_t op, input logic [63:0] v);
    monitor_mode <= 1'b1;
    cmd <= '{valid: 1'b1, op: op, scalar_source_reg: v};
    @(posedge mclk);
  endtask
  // Drops the strobe after the last op of a sequence
  task automatic idle();
    cmd <= '{valid: 1'b0, op: piit_pkg::PIIT_OP_NONE, scalar_source_reg: 64'h0};
  endtask
  // Leaves or re-enters monitor mode
  task automatic set_user(input logic user);
    monitor_mode <= !user;
  endtask
endmodule

// >>> periodic_interval_interrupt_timer_test.sv
`timescale 1ns/1ps
module periodic_interval_interrupt_timer_test;
  localparam logic [31:0] N = 32'h0000_0005;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  piit_pkg::piit_cmd_t cmd;
  logic monitor_mode;
  logic [31:0] timer_interval;
  logic [31:0] countdown_counter;
  piit_pkg::piit_stat_t status;
  logic interrupt_req;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;

  always #12.5 mclk = ~mclk;

  piit_issue_model piit_issue_model_i (.mclk(mclk), .cmd(cmd), .monitor_mode(monitor_mode));
  piit_timer piit_timer_i (.mclk(mclk), .rst_n(rst_n), .cmd(cmd), .monitor_mode(monitor_mode),
    .timer_interval(timer_interval), .countdown_counter(countdown_counter),
    .status(status), .interrupt_req(interrupt_req));

  // Compare and count
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic stop_test();
    if (num_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Advance n edges and settle
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Master clear leaves everything quiet
  task automatic t_reset();
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    chk("pending", 0, status.request_pending);
    chk("enabled", 0, status.request_enabled);
    chk("interval", 0, timer_interval);
    step(3);
  endtask

  // Load while disabled: low half taken, no request raised
  task automatic t_load_disabled();
    @(posedge mclk);
    piit_issue_model_i.issue(piit_pkg::PIIT_OP_CLEAR, 64'h0);
    piit_issue_model_i.issue(piit_pkg::PIIT_OP_DISABLE, 64'h0);
    piit_issue_model_i.issue(piit_pkg::PIIT_OP_LOAD, {32'ha5a5_a5a5, N});
    piit_issue_model_i.idle();
    #1;
    chk("interval", N, timer_interval);
    chk("counter", N, countdown_counter);
    step(14);
    chk("pending", 0, status.request_pending);
  endtask

  // Enabled countdown: decrement, reload, repeat
  task automatic t_period();
    @(posedge mclk);
    piit_issue_model_i.issue(piit_pkg::PIIT_OP_ENABLE, 64'h0);
    piit_issue_model_i.idle();
    #1;
    chk("counter", 1, countdown_counter);
    step(1);
    chk("counter", 0, countdown_counter);
    for (int i = 0; i < 2; i++) begin
      step(1);
      chk("reload", N, countdown_counter);
      chk("pending", 1, status.request_pending);
      chk("irq", 0, interrupt_req);
      for (int j = 1; j <= 5; j++) begin
        step(1);
        chk("counter", N - j, countdown_counter);
      end
    end
  endtask

  // User mode releases the held request, clear drops it, disable blocks it
  task automatic t_mode();
    @(posedge mclk);
    piit_issue_model_i.set_user(1'b1);
    #1;
    chk("irq", 1, interrupt_req);
    @(posedge mclk);
    piit_issue_model_i.issue(piit_pkg::PIIT_OP_CLEAR, 64'h0);
    piit_issue_model_i.idle();
    #1;
    chk("pending", 0, status.request_pending);
    chk("irq", 0, interrupt_req);
    @(posedge mclk);
    piit_issue_model_i.issue(piit_pkg::PIIT_OP_DISABLE, 64'h0);
    piit_issue_model_i.idle();
    step(8);
    chk("pending", 0, status.request_pending);
    chk("enabled", 0, status.request_enabled);
  endtask

  // Cycle ceiling
  always @(posedge mclk) begin
    cycles++;
    if (cycles >= 2000) begin
      num_errors++;
      stop_test();
    end
  end

  // Scenario sequence
  initial begin
    t_reset();
    t_load_disabled();
    t_period();
    t_mode();
    stop_test();
  end
endmodule
